// File: bench/alarm_bank_assertions.sv
// Read port and cradle word checks of the alarm bank
`timescale 1ns/100ps
module alarm_bank_assertions
    import alarm_bank_pkg::*;
#(parameter logic [15:0] BASE = MODULE1_BASE) (
    input wire logic clock, resetn, rd_en, rd_valid, rd_error,
    input wire logic cradle_pos_disc, cradle_disconnect_overdue, cradle_max_ops,
    input wire logic cradle_life_low, new_control_unit, drawer_pos_disc,
    input wire logic [15:0] cradle_valid, rd_addr, rd_data
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic [15:0] cw;
    logic in_rng;
    // Cradle word as the live inputs present it
    assign cw = {7'h0, drawer_pos_disc, 3'h0, new_control_unit, cradle_life_low,
        cradle_max_ops, cradle_disconnect_overdue, cradle_pos_disc};
    assign in_rng = rd_addr >= BASE && rd_addr <= BASE + 16'h001d;
    sequence s_calm;
        $stable(cw) && $stable(cradle_valid);
    endsequence
    sequence s_rd(a);
        rd_en && rd_addr == a - MODULE1_BASE + BASE && $stable(cw) && $stable(cradle_valid);
    endsequence
    a_read_answer: assert property (rd_en |=> rd_valid) else $error("read not answered");
    a_answer_cause: assert property (rd_valid |-> $past(rd_en)) else $error("answer without read");
    a_range_refused: assert property (rd_en && !in_rng |=> rd_error && rd_data == 16'h0000)
        else $error("outside read not refused");
    a_range_served: assert property (rd_en && in_rng |=> !rd_error) else $error("inside read refused");
    a_idle_quiet: assert property (!rd_valid |-> rd_data == 16'h0000 && !rd_error) else $error("idle not 0");
    a_motor_reserved: assert property (s_rd(MOTOR_ALARMS_ADDR) |=> rd_data == 16'h0000)
        else $error("motor word not 0");
    a_cradle_word: assert property (s_calm ##1 s_rd(CRADLE_DRAWER_ALARMS_ADDR) |=> rd_data == $past(cw, 2))
        else $error("cradle word wrong");
    a_cradle_quality: assert property (s_calm ##1 s_rd(CRADLE_ALARM_QUALITY_ADDR)
        |=> rd_data == ($past(cradle_valid, 2) & CRADLE_DRAWER_MASK)) else $error("cradle quality wrong");
endmodule // alarm_bank_assertions

// File: bench/alarm_reader_model.sv
// Register reader standing in for the bus client
`timescale 1ns/100ps
module alarm_reader_model (
    // Clock
    input wire logic clock,
    // Read request
    output logic rd_en,
    output logic [15:0] rd_addr
);
    initial rd_en = 1'b0;
    initial rd_addr = 16'h0000;
    // One read per call; back to back calls keep the request high
    task automatic rd(input logic [15:0] a);
        @(negedge clock);
        rd_en = 1'b1;
        rd_addr = a;
    endtask
    // Release; address inverted so a stale value never matches
    task automatic idle();
        @(negedge clock);
        rd_en = 1'b0;
        rd_addr = ~rd_addr;
    endtask
endmodule // alarm_reader_model

// File: bench/io_module_alarm_status_bank_tb.sv
// Self-checking bench of the alarm status bank
`timescale 1ns/100ps
module io_module_alarm_status_bank_tb;
    import alarm_bank_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, rd_en, rd_valid, rd_error;
    logic [15:0] rd_addr, rd_data, cw = '0, ow = '0, vc = '0, vm = '0, vo = '0, vp = '0, vd = '0;
    logic [9:0] pw = '0;
    logic [3:0] dw = '0;
    logic [31:0] seed = 32'd72410, r;
    logic [15:0] rd_data2, ad;
    logic rd_valid2, rd_error2;
    logic [33:0] q[$];
    logic [33:0] e;
    int bad_count = 0, total_checks = 0;
    always #2.5 clock = ~clock;
    io_module_alarm_status_bank i_dut (.clock, .resetn, .cradle_pos_disc(cw[0]),
        .cradle_disconnect_overdue(cw[1]), .cradle_max_ops(cw[2]), .cradle_life_low(cw[3]),
        .new_control_unit(cw[4]), .drawer_pos_disc(cw[8]), .contactor_not_closed(ow[0]),
        .contactor_not_opened(ow[1]), .dual_settings_disc(ow[3]), .predef_input_alarm(pw),
        .discrepancy_alarm(dw), .cradle_valid(vc), .motor_valid(vm), .other_app_valid(vo),
        .predef_input_valid(vp), .discrepancy_valid(vd), .rd_en, .rd_addr, .rd_data, .rd_valid, .rd_error);
    // Second module bank at its own base, sharing inputs and read request; its answer outputs are its own
    io_module_alarm_status_bank #(.BASE(MODULE2_BASE)) i_dut2 (.clock, .resetn, .cradle_pos_disc(cw[0]),
        .cradle_disconnect_overdue(cw[1]), .cradle_max_ops(cw[2]), .cradle_life_low(cw[3]),
        .new_control_unit(cw[4]), .drawer_pos_disc(cw[8]), .contactor_not_closed(ow[0]),
        .contactor_not_opened(ow[1]), .dual_settings_disc(ow[3]), .predef_input_alarm(pw),
        .discrepancy_alarm(dw), .cradle_valid(vc), .motor_valid(vm), .other_app_valid(vo),
        .predef_input_valid(vp), .discrepancy_valid(vd), .rd_en, .rd_addr, .rd_data(rd_data2),
        .rd_valid(rd_valid2), .rd_error(rd_error2));
    alarm_reader_model i_client (.clock, .rd_en, .rd_addr);
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected {error, data} for a read of address a by the bank at base b
    function automatic logic [16:0] ex(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] o;
        o = a - b;
        if (o > RESERVED_TAIL_LAST_ADDR - MODULE1_BASE) return 17'h10000;
        case (16'(o + MODULE1_BASE))
            CRADLE_ALARM_QUALITY_ADDR: return {1'b0, vc & CRADLE_DRAWER_MASK};
            CRADLE_DRAWER_ALARMS_ADDR: return {1'b0, cw & CRADLE_DRAWER_MASK};
            OTHER_APP_ALARM_QUALITY_ADDR: return {1'b0, vo & OTHER_APP_MASK};
            OTHER_APP_ALARMS_ADDR: return {1'b0, ow & OTHER_APP_MASK};
            PREDEF_INPUT_ALARM_QUALITY_ADDR: return {1'b0, vp & PREDEF_INPUT_MASK};
            PREDEF_INPUT_ALARMS_ADDR: return {7'h00, pw};
            DISCREPANCY_ALARM_QUALITY_ADDR: return {1'b0, vd & DISCREPANCY_MASK};
            DISCREPANCY_ALARMS_ADDR: return {13'h0000, dw};
            default: return 17'h00000;
        endcase
    endfunction
    task automatic chk(input string n, input logic [17:0] s, input logic [17:0] x);
        total_checks++;
        if (s !== x) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Oldest note against each answer of both banks; low half is bank 1
    always @(negedge clock) begin
        if (rd_valid === 1'b1 || rd_valid2 === 1'b1) begin
            e = q.size() ? q.pop_front() : '1;
            chk("bank 1 read", {rd_valid, rd_error, rd_data}, {1'b1, e[16:0]});
            chk("bank 2 read", {rd_valid2, rd_error2, rd_data2}, {1'b1, e[33:17]});
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock) resetn = 1'b1;
        for (int t = 0; t < 6; t++) begin
            {cw, ow} = xs();
            {vc, vo} = xs();
            {vm, vp} = xs();
            r = xs();
            {vd, pw, dw} = r[29:0];
            if (t == 5) {cw, ow, vc, vo, vm, vp, vd, pw, dw} = '1;
            repeat (3) @(negedge clock);
            // Sweep each bank's range plus one word either side
            for (int b = 0; b < 2; b++) begin
                for (int a = 0; a < 32; a++) begin
                    ad = 16'((b ? MODULE2_BASE : MODULE1_BASE) + a - 1);
                    i_client.rd(ad);
                    q.push_back({ex(ad, MODULE2_BASE), ex(ad, MODULE1_BASE)});
                end
            end
            r = xs();
            ad = r[15:0];
            i_client.rd(ad);
            q.push_back({ex(ad, MODULE2_BASE), ex(ad, MODULE1_BASE)});
            i_client.idle();
            for (int i = 0; i < 10 && q.size() > 0; i++) @(negedge clock);
            // Answers still owed when the bound runs out count as a mismatch
            if (q.size() > 0) begin
                bad_count++;
                break;
            end
            $display("test %0d done", t);
        end
        stop_test();
    end
endmodule // io_module_alarm_status_bank_tb
bind io_module_alarm_status_bank alarm_bank_assertions #(.BASE(BASE)) i_chk (.clock, .resetn, .rd_en,
    .rd_valid, .rd_error, .cradle_pos_disc, .cradle_disconnect_overdue, .cradle_max_ops, .cradle_life_low,
    .new_control_unit, .drawer_pos_disc, .cradle_valid, .rd_addr, .rd_data);

// File: logic/alarm_bank_pkg.sv
// Register map, field positions and reset values of the alarm status bank
package alarm_bank_pkg;

    // ==========================================================
    // Register addresses, first module
    localparam logic [15:0] CRADLE_ALARM_QUALITY_ADDR = 16'h3997;
    localparam logic [15:0] CRADLE_DRAWER_ALARMS_ADDR = 16'h3998;
    localparam logic [15:0] MOTOR_ALARM_QUALITY_ADDR = 16'h3999;
    localparam logic [15:0] MOTOR_ALARMS_ADDR = 16'h399a;
    localparam logic [15:0] OTHER_APP_ALARM_QUALITY_ADDR = 16'h399b;
    localparam logic [15:0] OTHER_APP_ALARMS_ADDR = 16'h399c;
    localparam logic [15:0] PREDEF_INPUT_ALARM_QUALITY_ADDR = 16'h399d;
    localparam logic [15:0] PREDEF_INPUT_ALARMS_ADDR = 16'h399e;
    localparam logic [15:0] DISCREPANCY_ALARM_QUALITY_ADDR = 16'h399f;
    localparam logic [15:0] DISCREPANCY_ALARMS_ADDR = 16'h39a0;
    localparam logic [15:0] RESERVED_TAIL_FIRST_ADDR = 16'h39a1;
    localparam logic [15:0] RESERVED_TAIL_LAST_ADDR = 16'h39a6;

    // Module bases; the second module bank has the same layout at its own base
    localparam logic [15:0] MODULE1_BASE = 16'h3989;
    localparam logic [15:0] MODULE2_BASE = 16'h4541;
    localparam logic [15:0] MODULE2_LAST = 16'h455e;

    // ==========================================================
    // Field positions
    localparam int CRADLE_POS_DISC_BIT = 0;
    localparam int CRADLE_DISCONNECT_OVERDUE_BIT = 1;
    localparam int CRADLE_MAX_OPS_BIT = 2;
    localparam int CRADLE_LIFE_LOW_BIT = 3;
    localparam int NEW_CONTROL_UNIT_BIT = 4;
    localparam int DRAWER_POS_DISC_BIT = 8;
    localparam int CONTACTOR_NOT_CLOSED_BIT = 0;
    localparam int CONTACTOR_NOT_OPENED_BIT = 1;
    localparam int DUAL_SETTINGS_DISC_BIT = 3;
    localparam int PREDEF_INPUT_COUNT = 10;
    localparam int DISCREPANCY_COUNT = 4;

    // Implemented-bit masks; reserved bits read as zero
    localparam logic [15:0] CRADLE_DRAWER_MASK = 16'h011f;
    localparam logic [15:0] MOTOR_MASK = 16'h0000;
    localparam logic [15:0] OTHER_APP_MASK = 16'h000b;
    localparam logic [15:0] PREDEF_INPUT_MASK = 16'h03ff;
    localparam logic [15:0] DISCREPANCY_MASK = 16'h000f;

    // ==========================================================
    // Reset values
    localparam logic [15:0] ALARM_RESET = 16'h0000;
    localparam logic [15:0] QUALITY_RESET = 16'h0000;

endpackage

// File: logic/alarm_word_reg.sv
// One alarm word with its quality word, reserved bits forced to zero
`timescale 1ns/100ps
module alarm_word_reg
    import alarm_bank_pkg::*;
#(
    parameter logic [15:0] MASK = 16'hffff
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Live alarm and validity levels
    input wire logic [15:0] alarm_in,
    input wire logic [15:0] valid_in,
    // Captured words
    output logic [15:0] alarm_q,
    output logic [15:0] quality_q
);

    // Per-bit capture; a bit outside MASK is reserved and stays zero
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_bit
            if (MASK[i]) begin : g_used
                // Own flop per bit, so each output bit has a single driver
                logic alarm_bit_q;
                logic quality_bit_q;
                always_ff @(posedge clock or negedge resetn) begin
                    if (!resetn) begin
                        alarm_bit_q <= ALARM_RESET[i];
                        quality_bit_q <= QUALITY_RESET[i];
                    end else begin
                        alarm_bit_q <= alarm_in[i];
                        quality_bit_q <= valid_in[i];
                    end
                end
                assign alarm_q[i] = alarm_bit_q;
                assign quality_q[i] = quality_bit_q;
            end else begin : g_rsvd
                assign alarm_q[i] = 1'b0;
                assign quality_q[i] = 1'b0;
            end
        end
    endgenerate

endmodule // alarm_word_reg

// File: logic/io_module_alarm_status_bank.sv
// Read-only alarm status bank of an input/output module, with read port
`timescale 1ns/100ps
module io_module_alarm_status_bank
    import alarm_bank_pkg::*;
#(
    parameter logic [15:0] BASE = MODULE1_BASE
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Cradle and drawer events
    input wire logic cradle_pos_disc,
    input wire logic cradle_disconnect_overdue,
    input wire logic cradle_max_ops,
    input wire logic cradle_life_low,
    input wire logic new_control_unit,
    input wire logic drawer_pos_disc,
    // Other application events
    input wire logic contactor_not_closed,
    input wire logic contactor_not_opened,
    input wire logic dual_settings_disc,
    // Predefined input contacts, bit order as in the alarm word
    input wire logic [PREDEF_INPUT_COUNT-1:0] predef_input_alarm,
    // Module discrepancy: crit hw, crit fw, noncrit hw, noncrit fw
    input wire logic [DISCREPANCY_COUNT-1:0] discrepancy_alarm,
    // Validity of each alarm bit, one word per alarm word
    input wire logic [15:0] cradle_valid,
    input wire logic [15:0] motor_valid,
    input wire logic [15:0] other_app_valid,
    input wire logic [15:0] predef_input_valid,
    input wire logic [15:0] discrepancy_valid,
    // Register read port
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_error
);

    // ==========================================================
    // Alarm word assembly
    logic [15:0] cradle_word;
    logic [15:0] other_app_word;
    logic [15:0] predef_word;
    logic [15:0] disc_word;

    // Cradle and drawer alarm positions
    always_comb begin
        cradle_word = 16'h0000;
        cradle_word[CRADLE_POS_DISC_BIT] = cradle_pos_disc;
        cradle_word[CRADLE_DISCONNECT_OVERDUE_BIT] = cradle_disconnect_overdue;
        cradle_word[CRADLE_MAX_OPS_BIT] = cradle_max_ops;
        cradle_word[CRADLE_LIFE_LOW_BIT] = cradle_life_low;
        cradle_word[NEW_CONTROL_UNIT_BIT] = new_control_unit;
        cradle_word[DRAWER_POS_DISC_BIT] = drawer_pos_disc;
    end

    // Other application alarm positions, bit 2 left reserved
    always_comb begin
        other_app_word = 16'h0000;
        other_app_word[CONTACTOR_NOT_CLOSED_BIT] = contactor_not_closed;
        other_app_word[CONTACTOR_NOT_OPENED_BIT] = contactor_not_opened;
        other_app_word[DUAL_SETTINGS_DISC_BIT] = dual_settings_disc;
    end

    assign predef_word = {{(16-PREDEF_INPUT_COUNT){1'b0}}, predef_input_alarm};
    assign disc_word = {{(16-DISCREPANCY_COUNT){1'b0}}, discrepancy_alarm};

    // ==========================================================
    // Captured words
    logic [15:0] cradle_q, cradle_qual_q;
    logic [15:0] motor_q, motor_qual_q;
    logic [15:0] other_q, other_qual_q;
    logic [15:0] predef_q, predef_qual_q;
    logic [15:0] disc_q, disc_qual_q;

    alarm_word_reg #(.MASK(CRADLE_DRAWER_MASK)) u_cradle (
        .clock(clock), .resetn(resetn), .alarm_in(cradle_word), .valid_in(cradle_valid),
        .alarm_q(cradle_q), .quality_q(cradle_qual_q)
    );
    // Motor word has no alarms; its quality word is all reserved too
    alarm_word_reg #(.MASK(MOTOR_MASK)) u_motor (
        .clock(clock), .resetn(resetn), .alarm_in(16'h0000), .valid_in(motor_valid),
        .alarm_q(motor_q), .quality_q(motor_qual_q)
    );
    alarm_word_reg #(.MASK(OTHER_APP_MASK)) u_other (
        .clock(clock), .resetn(resetn), .alarm_in(other_app_word), .valid_in(other_app_valid),
        .alarm_q(other_q), .quality_q(other_qual_q)
    );
    alarm_word_reg #(.MASK(PREDEF_INPUT_MASK)) u_predef (
        .clock(clock), .resetn(resetn), .alarm_in(predef_word), .valid_in(predef_input_valid),
        .alarm_q(predef_q), .quality_q(predef_qual_q)
    );
    alarm_word_reg #(.MASK(DISCREPANCY_MASK)) u_disc (
        .clock(clock), .resetn(resetn), .alarm_in(disc_word), .valid_in(discrepancy_valid),
        .alarm_q(disc_q), .quality_q(disc_qual_q)
    );

    // ==========================================================
    // Address decode, relative to this module's base
    logic [15:0] offset;
    logic hit_bank;
    logic [15:0] sel_data;

    // Second module instance uses BASE = MODULE2_BASE, same offsets
    assign offset = 16'(rd_addr - BASE);
    assign hit_bank = (offset <= 16'(RESERVED_TAIL_LAST_ADDR - MODULE1_BASE));

    // Word select strobes; a quality word sits one below its alarm word
    logic pick_cradle_qual;
    logic pick_cradle;
    logic pick_motor_qual;
    logic pick_motor;
    logic pick_other_qual;
    logic pick_other;
    logic pick_predef_qual;
    logic pick_predef;
    logic pick_disc_qual;
    logic pick_disc;

    assign pick_cradle_qual = (offset == 16'(CRADLE_ALARM_QUALITY_ADDR - MODULE1_BASE));
    assign pick_cradle = (offset == 16'(CRADLE_DRAWER_ALARMS_ADDR - MODULE1_BASE));
    assign pick_motor_qual = (offset == 16'(MOTOR_ALARM_QUALITY_ADDR - MODULE1_BASE));
    assign pick_motor = (offset == 16'(MOTOR_ALARMS_ADDR - MODULE1_BASE));
    assign pick_other_qual = (offset == 16'(OTHER_APP_ALARM_QUALITY_ADDR - MODULE1_BASE));
    assign pick_other = (offset == 16'(OTHER_APP_ALARMS_ADDR - MODULE1_BASE));
    assign pick_predef_qual = (offset == 16'(PREDEF_INPUT_ALARM_QUALITY_ADDR - MODULE1_BASE));
    assign pick_predef = (offset == 16'(PREDEF_INPUT_ALARMS_ADDR - MODULE1_BASE));
    assign pick_disc_qual = (offset == 16'(DISCREPANCY_ALARM_QUALITY_ADDR - MODULE1_BASE));
    assign pick_disc = (offset == 16'(DISCREPANCY_ALARMS_ADDR - MODULE1_BASE));

    // AND-OR read multiplexer; any other word of the range reads zero
    assign sel_data = ({16{pick_cradle_qual}} & cradle_qual_q)
        | ({16{pick_cradle}} & cradle_q)
        | ({16{pick_motor_qual}} & motor_qual_q)
        | ({16{pick_motor}} & motor_q)
        | ({16{pick_other_qual}} & other_qual_q)
        | ({16{pick_other}} & other_q)
        | ({16{pick_predef_qual}} & predef_qual_q)
        | ({16{pick_predef}} & predef_q)
        | ({16{pick_disc_qual}} & disc_qual_q)
        | ({16{pick_disc}} & disc_q);

    // ==========================================================
    // Registered read answer, one cycle after the request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
            rd_error <= 1'b0;
        end else begin
            rd_data <= (rd_en && hit_bank) ? sel_data : 16'h0000;
            rd_valid <= rd_en;
            rd_error <= rd_en && !hit_bank; // Outside the bank's range
        end
    end

endmodule // io_module_alarm_status_bank
